// [fsp_regs.vh]
// register offsets, field positions, reset values and timing counts of the framed serial port
`ifndef FSP_REGS_VH
`define FSP_REGS_VH
// ============================================================
// register byte offsets on the wishbone bus (32-bit words)
`define FSP_ADR_CONTROL_ONE 5'h00
`define FSP_ADR_CONTROL_TWO 5'h04
`define FSP_ADR_STATUS 5'h08
`define FSP_ADR_DATA_WINDOW 5'h0C
`define FSP_ADR_IRQ_ENABLE 5'h10
`define FSP_ADR_IRQ_FLAGS 5'h14
// ============================================================
// control_one fields
`define FSP_C1_CLOCK_EDGE 8
`define FSP_C1_SELECT_PIN_EN 7
`define FSP_C1_CLOCK_IDLE 6
`define FSP_C1_CONTROLLER 5
`define FSP_C1_WORD16 10
`define FSP_C1_OUT_DISABLE 11
// control_two fields
`define FSP_C2_FRAMING_EN 15
`define FSP_C2_SYNC_DIR 14
`define FSP_C2_SYNC_POL 13
`define FSP_C2_SYNC_EARLY_LATE 1
// status_reg fields
`define FSP_ST_MODULE_EN 15
`define FSP_ST_RX_OVERRUN 6
`define FSP_ST_TX_FULL 1
`define FSP_ST_RX_FULL 0
// irq flag and enable fields
`define FSP_IRQ_TRANSFER 0
`define FSP_IRQ_ERROR 1
// ============================================================
// reset values
`define FSP_RST_CONTROL 16'h0000
`define FSP_RST_DATA 16'h0000
// ============================================================
// timing: system clock period and local serial clock half period
`define FSP_CLK_NS 4
`define FSP_SCK_HALF_NS 24
`define FSP_SCK_HALF_CYC (`FSP_SCK_HALF_NS / `FSP_CLK_NS)
`endif

// [fsp_framed_serial.v]
// framed serial port: wishbone registers, serial clock, frame sync and word shifter
//
// Chosen here: the Wishbone slave port and the placing of the registers.
`include "fsp_regs.vh"
`default_nettype none
module fsp_framed_serial (
  input wire sys_clk,
  input wire resetn,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [4:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire serial_clock_pin_in,
  output wire serial_clock_pin_out,
  output wire serial_clock_pin_oe,
  input wire frame_sync_pin_in,
  output wire frame_sync_pin_out,
  output wire frame_sync_pin_oe,
  output reg serial_out_pin,
  output wire serial_out_pin_oe,
  input wire serial_in_pin,
  output wire transfer_irq,
  output wire err_irq
);
  // ============================================================
  // state codes, one-hot
  localparam [2:0] ST_IDLE = 3'h1; // waiting for a frame
  localparam [2:0] ST_SYNC = 3'h2; // sync shown, data not yet started
  localparam [2:0] ST_DATA = 3'h4; // shifting one word
  localparam [31:0] HALF_CYC_FULL = `FSP_SCK_HALF_CYC; // local clock half period in sys_clk cycles
  localparam [2:0] HALF_CYC = HALF_CYC_FULL[2:0]; // divider is 3 bits, so the half period must stay at or below 7

  // ============================================================
  // registers
  reg [15:0] control_one; // word width, clock level, controller select
  reg [15:0] control_two; // framing controls
  reg module_enable; // master enable of the port
  reg rx_overrun_flag; // sticky overrun
  reg rx_full_flag; // unread received word present
  reg transfer_irq_flag; // sticky word-complete flag
  reg err_irq_flag; // sticky error flag
  reg transfer_irq_enable; // gates transfer request
  reg err_irq_enable; // gates error request
  reg [15:0] tx_holding; // word waiting to be sent
  reg tx_pend; // tx_holding written and not yet taken
  reg [15:0] rx_word; // last received word
  reg [15:0] shifter; // serial shift register
  reg [2:0] state; // framing state
  reg [4:0] bit_cnt; // bits sampled in current word
  reg [4:0] fs_left; // transmit edges the sync pulse still lasts
  reg fs_act; // local sync pulse active
  reg [2:0] div_cnt; // local clock divider
  reg sck_loc; // local clock phase, before idle-level inversion
  reg [2:0] sck_sync; // pin clock synchroniser plus edge history
  reg [1:0] fs_sync; // pin sync synchroniser
  reg [1:0] sdi_sync; // pin data synchroniser

  // ============================================================
  // configuration decode
  wire framing_enable = control_two[`FSP_C2_FRAMING_EN];
  wire sync_direction = control_two[`FSP_C2_SYNC_DIR];
  wire sync_polarity = control_two[`FSP_C2_SYNC_POL];
  wire sync_early_late = control_two[`FSP_C2_SYNC_EARLY_LATE];
  wire controller_select = control_one[`FSP_C1_CONTROLLER];
  wire clock_idle_level = control_one[`FSP_C1_CLOCK_IDLE];
  wire output_pin_disable = control_one[`FSP_C1_OUT_DISABLE];
  wire word16 = control_one[`FSP_C1_WORD16];
  // clock_edge_select and select_pin_enable are stored for software only;
  // no framed logic reads them, so a stray setting cannot change timing
  wire active = module_enable & framing_enable;
  wire local_clk = active & controller_select;
  wire local_sync = active & ~sync_direction;
  wire [4:0] word_bits = word16 ? 5'h10 : 5'h08;

  // ============================================================
  // wishbone slave: ack one cycle after the request, dropped next cycle
  wire wb_req = wb_cyc_i & wb_stb_i;
  wire wb_take = wb_req & wb_ack_o; // effects happen at the ack edge
  wire wr_en = wb_take & wb_we_i;
  wire rd_en = wb_take & ~wb_we_i;
  wire wr_c1 = wr_en & (wb_adr_i == `FSP_ADR_CONTROL_ONE);
  wire wr_c2 = wr_en & (wb_adr_i == `FSP_ADR_CONTROL_TWO);
  wire wr_st = wr_en & (wb_adr_i == `FSP_ADR_STATUS);
  wire wr_dw = wr_en & (wb_adr_i == `FSP_ADR_DATA_WINDOW);
  wire wr_ie = wr_en & (wb_adr_i == `FSP_ADR_IRQ_ENABLE);
  wire wr_if = wr_en & (wb_adr_i == `FSP_ADR_IRQ_FLAGS);
  wire rd_dw = rd_en & (wb_adr_i == `FSP_ADR_DATA_WINDOW);

  // merge the two low byte lanes into a 16-bit register
  function [15:0] lane_merge;
    input [15:0] old;
    input [15:0] dat;
    input [1:0] sel;
    begin
      lane_merge = {sel[1] ? dat[15:8] : old[15:8], sel[0] ? dat[7:0] : old[7:0]};
    end
  endfunction

  // read multiplexer, registered into wb_dat_o; unmapped reads give zero
  reg [31:0] rd_mux;
  always @* begin
    rd_mux = 32'h0000_0000;
    case (wb_adr_i)
      `FSP_ADR_CONTROL_ONE: rd_mux = {16'h0000, control_one};
      `FSP_ADR_CONTROL_TWO: rd_mux = {16'h0000, control_two};
      `FSP_ADR_STATUS: begin
        rd_mux[`FSP_ST_MODULE_EN] = module_enable;
        rd_mux[`FSP_ST_RX_OVERRUN] = rx_overrun_flag;
        rd_mux[`FSP_ST_TX_FULL] = tx_pend;
        rd_mux[`FSP_ST_RX_FULL] = rx_full_flag;
      end
      `FSP_ADR_DATA_WINDOW: rd_mux = {16'h0000, rx_word};
      `FSP_ADR_IRQ_ENABLE: begin
        rd_mux[`FSP_IRQ_TRANSFER] = transfer_irq_enable;
        rd_mux[`FSP_IRQ_ERROR] = err_irq_enable;
      end
      `FSP_ADR_IRQ_FLAGS: begin
        rd_mux[`FSP_IRQ_TRANSFER] = transfer_irq_flag;
        rd_mux[`FSP_IRQ_ERROR] = err_irq_flag;
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // bus handshake and read data
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req & ~wb_ack_o;
      if (wb_req & ~wb_ack_o) begin
        wb_dat_o <= rd_mux;
      end
    end
  end

  // ============================================================
  // pin synchronisers: two flops each, third clock flop only for edges
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sck_sync <= 3'h0;
      fs_sync <= 2'h0;
      sdi_sync <= 2'h0;
    end else begin
      sck_sync <= {sck_sync[1:0], serial_clock_pin_in};
      fs_sync <= {fs_sync[0], frame_sync_pin_in};
      sdi_sync <= {sdi_sync[0], serial_in_pin};
    end
  end

  // ============================================================
  // local serial clock: free-running divider while framed controller
  wire tick = local_clk & (div_cnt == HALF_CYC - 3'h1);
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      div_cnt <= 3'h0;
      sck_loc <= 1'b0;
    end else if (!local_clk) begin
      div_cnt <= 3'h0; // parked at idle level while not generating
      sck_loc <= 1'b0;
    end else if (tick) begin
      div_cnt <= 3'h0;
      sck_loc <= ~sck_loc;
    end else begin
      div_cnt <= div_cnt + 3'h1;
    end
  end

  // pin-level edges of whichever clock is in use
  wire pin_now = sck_loc ^ clock_idle_level;
  wire clk_rise = local_clk ? (tick & ~pin_now) : (active & sck_sync[1] & ~sck_sync[2]);
  wire clk_fall = local_clk ? (tick & pin_now) : (active & ~sck_sync[1] & sck_sync[2]);
  wire tx_edge = clock_idle_level ? clk_fall : clk_rise;
  wire smp_edge = clock_idle_level ? clk_rise : clk_fall;
  // external sync seen at its programmed active level
  wire fs_seen = (fs_sync[1] == sync_polarity);
  // local sync length: a whole word with local clock, one clock otherwise
  wire [4:0] fs_len = local_clk ? word_bits : 5'h01;
  wire [3:0] msb = word16 ? 4'hF : 4'h7;
  wire done = (state == ST_DATA) & smp_edge & (bit_cnt == word_bits - 5'h01);

  // ============================================================
  // framing state machine, shifter and local sync pulse
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state <= ST_IDLE;
      shifter <= `FSP_RST_DATA;
      bit_cnt <= 5'h00;
      fs_act <= 1'b0;
      fs_left <= 5'h00;
      serial_out_pin <= 1'b0;
    end else if (!active) begin
      state <= ST_IDLE; // leaving framed mode aborts any word
      bit_cnt <= 5'h00;
      fs_act <= 1'b0;
      fs_left <= 5'h00;
    end else begin
      // sync pulse countdown on transmit edges
      if (tx_edge & fs_act) begin
        fs_left <= fs_left - 5'h01;
        if (fs_left == 5'h01) begin
          fs_act <= 1'b0;
        end
      end
      case (state)
        ST_IDLE: begin
          if (local_sync & tx_pend & tx_edge) begin
            fs_act <= 1'b1;
            fs_left <= fs_len;
            if (sync_early_late) begin
              shifter <= tx_holding; // late: data with the pulse
              serial_out_pin <= tx_holding[msb];
              bit_cnt <= 5'h00;
              state <= ST_DATA;
            end else begin
              state <= ST_SYNC; // early: one clock ahead of data
            end
          end else if (!local_sync & smp_edge & fs_seen) begin
            state <= ST_SYNC;
          end
        end
        ST_SYNC: begin
          if (tx_edge) begin
            shifter <= tx_holding;
            serial_out_pin <= tx_holding[msb];
            bit_cnt <= 5'h00;
            state <= ST_DATA;
          end
        end
        ST_DATA: begin
          if (smp_edge) begin
            shifter <= {shifter[14:0], sdi_sync[1]};
            bit_cnt <= bit_cnt + 5'h01;
            if (done) begin
              state <= ST_IDLE;
            end
          end else if (tx_edge) begin
            serial_out_pin <= shifter[msb];
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // received word as it will be stored, width-trimmed
  wire [15:0] rx_new = {shifter[14:0], sdi_sync[1]};
  wire [15:0] rx_trim = word16 ? rx_new : {8'h00, rx_new[7:0]};
  // a word starts when the shifter is loaded from tx_holding
  wire take_tx = active & tx_edge &
    (((state == ST_IDLE) & local_sync & tx_pend & sync_early_late) | (state == ST_SYNC));
  wire overrun = done & (rx_full_flag | rx_overrun_flag);
  wire rx_load = done & ~rx_full_flag & ~rx_overrun_flag;

  // ============================================================
  // software registers and sticky flags; hardware set wins over clear
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      control_one <= `FSP_RST_CONTROL;
      control_two <= `FSP_RST_CONTROL;
      module_enable <= 1'b0;
      rx_overrun_flag <= 1'b0;
      rx_full_flag <= 1'b0;
      transfer_irq_flag <= 1'b0;
      err_irq_flag <= 1'b0;
      transfer_irq_enable <= 1'b0;
      err_irq_enable <= 1'b0;
      tx_holding <= `FSP_RST_DATA;
      tx_pend <= 1'b0;
      rx_word <= `FSP_RST_DATA;
    end else begin
      if (wr_c1) begin
        control_one <= lane_merge(control_one, wb_dat_i[15:0], wb_sel_i[1:0]);
      end
      if (wr_c2) begin
        control_two <= lane_merge(control_two, wb_dat_i[15:0], wb_sel_i[1:0]);
      end
      if (wr_st & wb_sel_i[1]) begin
        module_enable <= wb_dat_i[`FSP_ST_MODULE_EN];
      end
      if (wr_ie & wb_sel_i[0]) begin
        transfer_irq_enable <= wb_dat_i[`FSP_IRQ_TRANSFER];
        err_irq_enable <= wb_dat_i[`FSP_IRQ_ERROR];
      end
      // overrun: only software clears it, by writing zero
      if (overrun) begin
        rx_overrun_flag <= 1'b1;
      end else if (wr_st & wb_sel_i[0] & ~wb_dat_i[`FSP_ST_RX_OVERRUN]) begin
        rx_overrun_flag <= 1'b0;
      end
      // flags: write one to clear, a same-cycle event keeps them set
      if (rx_load) begin
        transfer_irq_flag <= 1'b1;
      end else if (wr_if & wb_sel_i[0] & wb_dat_i[`FSP_IRQ_TRANSFER]) begin
        transfer_irq_flag <= 1'b0;
      end
      if (overrun) begin
        err_irq_flag <= 1'b1;
      end else if (wr_if & wb_sel_i[0] & wb_dat_i[`FSP_IRQ_ERROR]) begin
        err_irq_flag <= 1'b0;
      end
      // received word: a new word is discarded while the old is unread
      if (rx_load) begin
        rx_word <= rx_trim;
        rx_full_flag <= 1'b1;
      end else if (rd_dw | ~module_enable) begin
        rx_full_flag <= 1'b0; // disable also empties, as recovery needs
      end
      // transmit holding word; a write during a frame waits for the next
      if (wr_dw) begin
        tx_holding <= lane_merge(tx_holding, wb_dat_i[15:0], wb_sel_i[1:0]);
        tx_pend <= 1'b1;
      end else if (take_tx | ~module_enable) begin
        tx_pend <= 1'b0;
      end
    end
  end

  // ============================================================
  // pin drive and interrupt requests
  assign serial_clock_pin_out = pin_now;
  assign serial_clock_pin_oe = local_clk;
  assign frame_sync_pin_out = sync_polarity ? fs_act : ~fs_act;
  assign frame_sync_pin_oe = local_sync;
  assign serial_out_pin_oe = active & ~output_pin_disable;
  assign transfer_irq = transfer_irq_flag & transfer_irq_enable;
  assign err_irq = err_irq_flag & err_irq_enable;

endmodule // fsp_framed_serial
`default_nettype wire

// [fsp_framed_serial_asserts.sv]
// concurrent checks on the framed serial port bus and pins
`default_nettype none
module fsp_framed_serial_asserts (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic serial_clock_pin_out,
  input wire logic serial_clock_pin_oe,
  input wire logic frame_sync_pin_out,
  input wire logic frame_sync_pin_oe,
  input wire logic serial_out_pin,
  input wire logic serial_out_pin_oe,
  input wire logic transfer_irq,
  input wire logic err_irq
);
  // ==========
  // helpers
  logic sck_d1, sck_d2, sck_d3; // last sampled clock levels
  wire wr_ack = wb_ack_o & wb_we_i; // a write completing
  // clock moved lately; three deep to allow for output register delay
  wire sck_moved = (serial_clock_pin_out != sck_d1) | (sck_d1 != sck_d2) | (sck_d2 != sck_d3);
  // clock level history
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      {sck_d3, sck_d2, sck_d1} <= 3'h0;
    end else begin
      {sck_d3, sck_d2, sck_d1} <= {sck_d2, sck_d1, serial_clock_pin_out};
    end
  end
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);
  // ==========
  // bus and pins
  a_ack_after_req: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
    else $error("ack missing after request");
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_upper_read_zero: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0)
    else $error("read data upper half not zero");
  a_sck_free_run: assert property (serial_clock_pin_oe |-> ##[1:7] ($changed(serial_clock_pin_out) || !serial_clock_pin_oe))
    else $error("local serial clock stopped");
  a_sdo_on_edge: assert property ((serial_out_pin_oe && $past(serial_out_pin_oe) && serial_clock_pin_oe
    && $changed(serial_out_pin)) |-> sck_moved)
    else $error("data out moved away from clock edge");
  a_sync_on_edge: assert property ((frame_sync_pin_oe && $past(frame_sync_pin_oe) && serial_clock_pin_oe
    && $changed(frame_sync_pin_out)) |-> sck_moved)
    else $error("sync out moved away from clock edge");
  a_xfer_sw_clear: assert property ($fell(transfer_irq) |-> ($past(wr_ack) || $past(wr_ack, 2)))
    else $error("transfer request dropped without a write");
  a_err_sw_clear: assert property ($fell(err_irq) |-> ($past(wr_ack) || $past(wr_ack, 2)))
    else $error("error request dropped without a write");
endmodule // fsp_framed_serial_asserts
bind fsp_framed_serial fsp_framed_serial_asserts chk (.sys_clk(sys_clk), .resetn(resetn), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .serial_clock_pin_out(serial_clock_pin_out), .serial_clock_pin_oe(serial_clock_pin_oe),
  .frame_sync_pin_out(frame_sync_pin_out), .frame_sync_pin_oe(frame_sync_pin_oe), .serial_out_pin(serial_out_pin),
  .serial_out_pin_oe(serial_out_pin_oe), .transfer_irq(transfer_irq), .err_irq(err_irq));
`default_nettype wire

// [fsp_partner.sv]
// far-side serial partner: clock, frame sync and word exchange
`default_nettype none
module fsp_partner (
  input wire logic ext_clk, // partner owns the clock
  input wire logic ext_sync, // partner owns the sync
  input wire logic idle,
  input wire logic pol,
  input wire logic [4:0] nbits,
  input wire logic late, // first data bit comes with the sync
  input wire logic go, // request one sync pulse
  input wire logic [15:0] tx,
  input wire logic sck,
  input wire logic fs,
  input wire logic sdo,
  output logic pclk,
  output logic pfs,
  output logic psdi,
  output logic [15:0] rx
);
  timeunit 1ns;
  timeprecision 100ps;
  logic armed, fs_q, pend, pulse;
  logic [4:0] cnt;
  logic [15:0] sh;
  // ==========
  // free-running clock, phase unrelated to the system clock
  initial begin
    {armed, fs_q, pend, pulse, psdi, cnt, sh, rx} = '0;
    pclk = 1'b0;
    #7;
    forever #24 pclk = ext_clk ? ~pclk : idle;
  end
  always @(posedge go) pend = 1'b1;
  // sync line rests at the inactive level of the present polarity, so a polarity change makes no false pulse
  assign pfs = pulse ? pol : ~pol;
  // ==========
  // transmit edges drive, sample edges capture
  always @(sck) begin
    if (sck != idle) begin
      pulse <= ext_sync && pend; // one clock pulse
      if (ext_sync && pend) pend = 1'b0;
      if (armed || cnt != 0) begin
        psdi <= sh[nbits - 1];
        sh <= sh << 1;
      end else begin
        psdi <= late ? tx[nbits - 1] : ~psdi; // late: first bit must stand before the sync is seen
      end
      if (armed) cnt <= nbits;
      armed <= 1'b0;
    end else begin
      fs_q <= (fs === pol);
      if ((fs === pol) && !fs_q && cnt == 0) begin
        if (late) begin
          rx <= {rx[14:0], sdo}; // late sync: first bit is already on the line
          cnt <= nbits - 5'd1;
          sh <= tx << 1;
        end else begin
          armed <= 1'b1;
          sh <= tx;
        end
      end else if (cnt != 0) begin
        rx <= {rx[14:0], sdo};
        cnt <= cnt - 5'd1;
      end
    end
  end
endmodule // fsp_partner
`default_nettype wire

// [tb_top.sv]
// self-checking bench for the framed serial port
`include "fsp_regs.vh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk, resetn, cyc, stb, we, go, ext_clk, ext_sync, idle, pol, late;
  logic [4:0] adr, nbits;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, q;
  logic ack, sck_o, sck_oe, fs_o, fs_oe, sdo, sdo_oe, tirq, eirq, pclk, pfs, psdi;
  logic [15:0] ptx, prx;
  int mismatches, checked;
  // resolved pins: a released data line shows the inverse of the design's register
  wire sck_w = sck_oe ? sck_o : pclk;
  wire fs_w = fs_oe ? fs_o : pfs;
  wire sdo_w = sdo_oe ? sdo : ~sdo;
  fsp_framed_serial uut (.sys_clk(sys_clk), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .serial_clock_pin_in(sck_w), .serial_clock_pin_out(sck_o), .serial_clock_pin_oe(sck_oe),
    .frame_sync_pin_in(fs_w), .frame_sync_pin_out(fs_o), .frame_sync_pin_oe(fs_oe), .serial_out_pin(sdo),
    .serial_out_pin_oe(sdo_oe), .serial_in_pin(psdi), .transfer_irq(tirq), .err_irq(eirq));
  fsp_partner far (.ext_clk(ext_clk), .ext_sync(ext_sync), .idle(idle), .pol(pol), .nbits(nbits), .go(go),
    .late(late), .tx(ptx), .sck(sck_w), .fs(fs_w), .sdo(sdo_w), .pclk(pclk), .pfs(pfs), .psdi(psdi), .rx(prx));
  // ==========
  // tasks
  task automatic complete_run;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one classic cycle, held until ack is sampled
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat;
    {cyc, stb} <= 2'b00;
    if (n >= 20) mismatches++;
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] exp, input string nm);
    bus(1'b0, a, 32'h0);
    check(nm, q, exp);
  endtask
  // poll a status bit, bounded
  task automatic wait_st(input int b);
    int k;
    k = 0;
    do begin
      bus(1'b0, `FSP_ADR_STATUS, 32'h0);
      k++;
    end while (q[b] !== 1'b1 && k < 300);
    if (q[b] !== 1'b1) mismatches++;
  endtask
  // disable, clear, configure, re-enable; also the overrun recovery
  task automatic setup(input logic [15:0] c1, input logic [15:0] c2);
    bus(1'b1, `FSP_ADR_STATUS, 32'h0);
    bus(1'b1, `FSP_ADR_IRQ_FLAGS, 32'h3);
    bus(1'b1, `FSP_ADR_CONTROL_ONE, {16'h0, c1});
    bus(1'b1, `FSP_ADR_CONTROL_TWO, {16'h0, c2});
    {idle, pol, ext_clk, ext_sync, late} <= {c1[6], c2[13], ~c1[5], c2[14], c2[1]};
    nbits <= c1[10] ? 5'd16 : 5'd8;
    bus(1'b1, `FSP_ADR_STATUS, 32'h8000);
  endtask
  task automatic xfer(input logic [15:0] dev, input logic [15:0] farw);
    ptx <= farw;
    bus(1'b1, `FSP_ADR_DATA_WINDOW, {16'h0, dev});
    go <= ext_sync;
    @(posedge sys_clk);
    go <= 1'b0;
    wait_st(`FSP_ST_RX_FULL);
  endtask
  // ==========
  // clock, watchdog, tests
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  initial begin
    #100000;
    mismatches++;
    complete_run;
  end
  initial begin
    {resetn, cyc, stb, we, go, ext_clk, ext_sync, idle, pol, late, adr, wdat, ptx} = '0;
    {sel, nbits, mismatches, checked} = {4'h3, 5'd8, 64'h0};
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    rd(`FSP_ADR_STATUS, 32'h0, "status reset");
    rd(`FSP_ADR_CONTROL_TWO, 32'h0, "control_two reset");
    rd(5'h1C, 32'h0, "unmapped read");
    // local clock and sync, active high, 8 bit; ignored bits set
    setup(16'h01A0, 16'hA000);
    bus(1'b1, `FSP_ADR_IRQ_ENABLE, 32'h3);
    check("clock drive", 32'(sck_oe), 32'h1);
    xfer(16'h00A5, 16'h003C);
    rd(`FSP_ADR_DATA_WINDOW, 32'h3C, "rx local");
    check("far rx local", 32'(prx[7:0]), 32'hA5);
    check("transfer irq", 32'(tirq), 32'h1);
    // overrun: second word kept, third dropped
    xfer(16'h005A, 16'h00C3);
    ptx <= 16'h0077;
    bus(1'b1, `FSP_ADR_DATA_WINDOW, 32'h11);
    wait_st(`FSP_ST_RX_OVERRUN);
    rd(`FSP_ADR_STATUS, 32'h8041, "status overrun");
    check("err irq", 32'(eirq), 32'h1);
    rd(`FSP_ADR_IRQ_FLAGS, 32'h3, "flags");
    rd(`FSP_ADR_DATA_WINDOW, 32'hC3, "kept word");
    bus(1'b1, `FSP_ADR_IRQ_ENABLE, 32'h0);
    @(posedge sys_clk); // the enable write lands at the ack edge, look one edge later
    check("masked irqs", 32'({tirq, eirq}), 32'h0);
    bus(1'b1, `FSP_ADR_IRQ_ENABLE, 32'h3);
    rd(`FSP_ADR_STATUS, 32'h8040, "overrun sticks");
    // local clock and sync, late pulse: sync and first bit together
    setup(16'h0020, 16'hA002);
    xfer(16'h00C6, 16'h0039);
    rd(`FSP_ADR_DATA_WINDOW, 32'h39, "rx late");
    check("far rx late", 32'(prx[7:0]), 32'hC6);
    // external clock and sync, idle high, active low, 16 bit
    setup(16'h0440, 16'hC000);
    rd(`FSP_ADR_STATUS, 32'h8000, "recovered");
    xfer(16'hBEEF, 16'h1234);
    rd(`FSP_ADR_DATA_WINDOW, 32'h1234, "rx ext");
    check("far rx ext", 32'(prx), 32'hBEEF);
    check("pins input", 32'({sck_oe, fs_oe}), 32'h0);
    // external clock, local sync pulse
    setup(16'h0000, 16'hA000);
    xfer(16'h0096, 16'h0069);
    rd(`FSP_ADR_DATA_WINDOW, 32'h69, "rx sync out");
    check("far rx sync out", 32'(prx[7:0]), 32'h96);
    check("pins mixed", 32'({sck_oe, fs_oe}), 32'h1);
    // local clock, external sync, receive only
    setup(16'h0820, 16'hE000);
    xfer(16'h00FF, 16'h00C3);
    rd(`FSP_ADR_DATA_WINDOW, 32'hC3, "rx sync in");
    check("out released", 32'(sdo_oe), 32'h0);
    check("far rx released", 32'(prx[7:0]), 32'h00);
    check("transfer irq", 32'(tirq), 32'h1);
    complete_run;
  end
endmodule // tb_top
`default_nettype wire
